//--- rtl/odc_config_cmds.sv
`timescale 1ns/1ps
`default_nettype none
module odc_config_cmds #(
  parameter int DIV_WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pre-charge and remap settings
  output logic [1:0] prechargeSpeed,
  output logic addrVertical,
  output logic segRemap,
  output logic subpixelReverse,
  output logic comSwap,
  output logic comReverse,
  output logic comSplit,
  output logic [1:0] colourDepth,
  // row settings
  output logic [7:0] startLine,
  output logic [7:0] displayOffset,
  output logic [7:0] muxRatio,
  // mode and power
  output logic [1:0] displayMode,
  output logic [1:0] powerState,
  // dim settings
  output logic [7:0] dimContrastA,
  output logic [7:0] dimContrastB,
  output logic [7:0] dimContrastC,
  output logic [4:0] dimPrecharge,
  // phase timing
  output logic [4:0] phase1Cycles,
  output logic [3:0] phase2Cycles,
  output logic displayClockTick,
  output logic phase1Active,
  output logic phase2Active
);
  // parameter bytes expected after each opcode
  function automatic logic [2:0] paramCount(input logic [7:0] op);
    case (op)
      odc_pkg::OP_PRECHARGE_SPEED,
      odc_pkg::OP_REMAP,
      odc_pkg::OP_START_LINE,
      odc_pkg::OP_OFFSET,
      odc_pkg::OP_MUX_RATIO,
      odc_pkg::OP_PHASE_PERIOD: paramCount = odc_pkg::PCNT_ONE;
      odc_pkg::OP_DIM_SETUP: paramCount = odc_pkg::PCNT_DIM;
      default: paramCount = odc_pkg::PCNT_NONE;
    endcase
  endfunction

  // opcodes that act with no parameter
  function automatic logic isSingle(input logic [7:0] op);
    case (op)
      odc_pkg::OP_MODE_NORMAL,
      odc_pkg::OP_MODE_ALL_ON,
      odc_pkg::OP_MODE_ALL_OFF,
      odc_pkg::OP_MODE_INVERSE,
      odc_pkg::OP_DISPLAY_DIM,
      odc_pkg::OP_DISPLAY_OFF,
      odc_pkg::OP_DISPLAY_ON: isSingle = 1'b1;
      default: isSingle = 1'b0;
    endcase
  endfunction

  // stored state
  odc_pkg::odc_state_t state;
  odc_pkg::odc_state_t next_state;
  logic [7:0] opcode;
  logic [2:0] paramIdx;
  logic [2:0] paramNeed;
  logic [7:0] paramBuf [0:odc_pkg::MAX_PARAMS-1];
  logic [7:0] remap;
  logic wideBus;
  logic [DIV_WIDTH-1:0] divider;

  // bus decode
  wire busReq = avs_read | avs_write;
  wire busTake = busReq & ~avs_waitrequest;
  wire wrTake = busTake & avs_write;
  wire cmdWrite = wrTake & (avs_address == odc_pkg::REG_CMD) & avs_byteenable[0];
  wire cfgWrite = wrTake & (avs_address == odc_pkg::REG_CONFIG) & avs_byteenable[0];
  wire [7:0] inByte = avs_writedata[7:0];
  wire inIsParam = avs_byteenable[1] & avs_writedata[odc_pkg::CMD_DC_BIT];
  wire [2:0] inNeed = paramCount(inByte);
  wire inSingle = isSingle(inByte);
  wire lastParam = (paramIdx == (paramNeed - 3'h1));

  // interpreter next state
  always_comb begin
    next_state = state;
    case (state)
      odc_pkg::ST_IDLE,
      odc_pkg::ST_COLLECT,
      odc_pkg::ST_APPLY: begin
        if (state == odc_pkg::ST_APPLY) begin
          next_state = odc_pkg::ST_IDLE;
        end
        if (cmdWrite && !inIsParam) begin
          if (inNeed != odc_pkg::PCNT_NONE) begin
            next_state = odc_pkg::ST_COLLECT;
          end else if (inSingle) begin
            next_state = odc_pkg::ST_APPLY;
          end else begin
            next_state = odc_pkg::ST_IDLE;
          end
        end else if (cmdWrite && state == odc_pkg::ST_COLLECT && lastParam) begin
          next_state = odc_pkg::ST_APPLY;
        end
      end
      default: next_state = odc_pkg::ST_IDLE;
    endcase
  end

  // state, opcode and parameter index
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= odc_pkg::ST_IDLE;
      opcode <= 8'h00;
      paramIdx <= 3'h0;
      paramNeed <= 3'h0;
    end else begin
      state <= next_state;
      if (cmdWrite && !inIsParam) begin
        opcode <= inByte;
        paramNeed <= inNeed;
        paramIdx <= 3'h0;
      end else if (cmdWrite && state == odc_pkg::ST_COLLECT) begin
        paramIdx <= paramIdx + 3'h1;
      end
    end
  end

  // parameter capture, only while collecting
  always_ff @(posedge ref_clk) begin
    if (cmdWrite && inIsParam && state == odc_pkg::ST_COLLECT) begin
      paramBuf[paramIdx] <= inByte;
    end
  end

  // apply strobes and validity checks
  wire applying = (state == odc_pkg::ST_APPLY);
  wire [7:0] p0 = paramBuf[0];
  wire applySpeed = applying & (opcode == odc_pkg::OP_PRECHARGE_SPEED);
  wire applyRemap = applying & (opcode == odc_pkg::OP_REMAP);
  wire applyStart = applying & (opcode == odc_pkg::OP_START_LINE) & (p0 <= odc_pkg::ROW_MAX);
  wire applyOffset = applying & (opcode == odc_pkg::OP_OFFSET) & (p0 <= odc_pkg::ROW_MAX);
  wire muxValid = (p0 >= odc_pkg::MUX_MIN) & (p0 <= odc_pkg::MUX_MAX);
  wire applyMux = applying & (opcode == odc_pkg::OP_MUX_RATIO) & muxValid;
  wire applyDim = applying & (opcode == odc_pkg::OP_DIM_SETUP);
  wire applyPhase = applying & (opcode == odc_pkg::OP_PHASE_PERIOD);
  wire applyPhase1 = applyPhase & (p0[3:0] >= odc_pkg::PHASE1_MIN);
  wire applyPhase2 = applyPhase & (p0[7:4] >= odc_pkg::PHASE2_MIN);
  wire applyMode = applying & (opcode[7:2] == odc_pkg::OP_MODE_NORMAL[7:2]);
  wire applyDimOn = applying & (opcode == odc_pkg::OP_DISPLAY_DIM);
  wire applyOff = applying & (opcode == odc_pkg::OP_DISPLAY_OFF);
  wire applyOn = applying & (opcode == odc_pkg::OP_DISPLAY_ON);
  wire [1:0] next_colourDepth = wideBus ? odc_pkg::DEPTH_256K :
      remap[odc_pkg::REMAP_DEPTH_MSB:odc_pkg::REMAP_DEPTH_LSB];

  // pre-charge speed and remap byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prechargeSpeed <= odc_pkg::RST_SPEED;
      remap <= odc_pkg::RST_REMAP;
      colourDepth <= odc_pkg::RST_REMAP[odc_pkg::REMAP_DEPTH_MSB:odc_pkg::REMAP_DEPTH_LSB];
    end else begin
      if (applySpeed) prechargeSpeed <= p0[1:0];
      if (applyRemap) remap <= p0;
      colourDepth <= next_colourDepth;
    end
  end

  // decoded remap fields
  assign addrVertical = remap[odc_pkg::REMAP_VERT_BIT];
  assign segRemap = remap[odc_pkg::REMAP_SEGREV_BIT];
  assign subpixelReverse = remap[odc_pkg::REMAP_ORDER_BIT];
  assign comSwap = remap[odc_pkg::REMAP_SWAP_BIT];
  assign comReverse = remap[odc_pkg::REMAP_SCANREV_BIT];
  assign comSplit = remap[odc_pkg::REMAP_SPLIT_BIT];

  // row settings, out-of-range values dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      startLine <= odc_pkg::RST_START;
      displayOffset <= odc_pkg::RST_OFFSET;
      muxRatio <= odc_pkg::RST_MUX;
    end else begin
      if (applyStart) startLine <= p0;
      if (applyOffset) displayOffset <= p0;
      if (applyMux) muxRatio <= p0;
    end
  end

  // display mode and power state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      displayMode <= odc_pkg::MODE_NORMAL;
      powerState <= odc_pkg::PWR_SLEEP;
    end else begin
      if (applyMode) displayMode <= opcode[1:0];
      if (applyDimOn) powerState <= odc_pkg::PWR_DIM;
      if (applyOff) powerState <= odc_pkg::PWR_SLEEP;
      if (applyOn) powerState <= odc_pkg::PWR_NORMAL;
    end
  end

  // dim settings, reserved first byte discarded
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dimContrastA <= odc_pkg::RST_DIM;
      dimContrastB <= odc_pkg::RST_DIM;
      dimContrastC <= odc_pkg::RST_DIM;
      dimPrecharge <= odc_pkg::RST_DIM_PRE;
    end else if (applyDim) begin
      dimContrastA <= paramBuf[1];
      dimContrastB <= paramBuf[2];
      dimContrastC <= paramBuf[3];
      dimPrecharge <= paramBuf[4][4:0];
    end
  end

  // phase periods, each nibble checked on its own
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase1Cycles <= odc_pkg::RST_PHASE1_CYC;
      phase2Cycles <= odc_pkg::RST_PHASE2_CYC;
    end else begin
      if (applyPhase1) phase1Cycles <= {p0[3:0], 1'b1};
      if (applyPhase2) phase2Cycles <= p0[7:4];
    end
  end

  // configuration register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wideBus <= 1'b0;
      divider <= DIV_WIDTH'(odc_pkg::RST_DIV);
    end else if (cfgWrite) begin
      wideBus <= avs_writedata[odc_pkg::CFG_WIDE_BIT];
      divider <= DIV_WIDTH'(avs_writedata[odc_pkg::CFG_DIV_MSB:odc_pkg::CFG_DIV_LSB]);
    end
  end

  // read data selection
  wire busy = (state != odc_pkg::ST_IDLE);
  wire [31:0] rdCmd = {20'h00000, paramIdx, busy, opcode};
  wire [31:0] rdCfg = {24'h000000, 4'(divider), 3'h0, wideBus};
  wire [31:0] rdRemap = {10'h000, powerState, 2'h0, displayMode, 2'h0, colourDepth,
      2'h0, prechargeSpeed, remap};
  wire [31:0] rdLines = {8'h00, muxRatio, displayOffset, startLine};
  wire [31:0] rdDim = {3'h0, dimPrecharge, dimContrastC, dimContrastB, dimContrastA};
  wire [31:0] rdPhase = {12'h000, phase2Cycles, 3'h0, phase1Cycles, phase2Cycles,
      phase1Cycles[4:1]};
  wire [31:0] rdMux = (avs_address == odc_pkg::REG_CMD) ? rdCmd :
      (avs_address == odc_pkg::REG_CONFIG) ? rdCfg :
      (avs_address == odc_pkg::REG_REMAP_STATUS) ? rdRemap :
      (avs_address == odc_pkg::REG_LINES) ? rdLines :
      (avs_address == odc_pkg::REG_DIM) ? rdDim :
      (avs_address == odc_pkg::REG_PHASE) ? rdPhase : 32'h00000000;

  // one wait cycle per access, read data loaded with the release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(busReq & avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= rdMux;
    end
  end

  // divided display clock
  odc_clk_div #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .divider(divider),
    .tick(displayClockTick)
  );

  // phase sequencing while the panel is on
  odc_phase_seq u_phase (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(displayClockTick),
    .run(powerState != odc_pkg::PWR_SLEEP),
    .phase1Len(phase1Cycles),
    .phase2Len(phase2Cycles),
    .phase1Active(phase1Active),
    .phase2Active(phase2Active)
  );
endmodule
`default_nettype wire

//--- rtl/odc_pkg.sv
`default_nettype none
package odc_pkg;
  // command opcodes
  localparam logic [7:0] OP_PRECHARGE_SPEED = 8'h8A;
  localparam logic [7:0] OP_REMAP = 8'hA0;
  localparam logic [7:0] OP_START_LINE = 8'hA1;
  localparam logic [7:0] OP_OFFSET = 8'hA2;
  localparam logic [7:0] OP_MODE_NORMAL = 8'hA4;
  localparam logic [7:0] OP_MODE_ALL_ON = 8'hA5;
  localparam logic [7:0] OP_MODE_ALL_OFF = 8'hA6;
  localparam logic [7:0] OP_MODE_INVERSE = 8'hA7;
  localparam logic [7:0] OP_MUX_RATIO = 8'hA8;
  localparam logic [7:0] OP_DIM_SETUP = 8'hAB;
  localparam logic [7:0] OP_DISPLAY_DIM = 8'hAC;
  localparam logic [7:0] OP_DISPLAY_OFF = 8'hAE;
  localparam logic [7:0] OP_DISPLAY_ON = 8'hAF;
  localparam logic [7:0] OP_PHASE_PERIOD = 8'hB1;

  // parameter byte counts
  localparam logic [2:0] PCNT_NONE = 3'h0;
  localparam logic [2:0] PCNT_ONE = 3'h1;
  localparam logic [2:0] PCNT_DIM = 3'h5;
  localparam int MAX_PARAMS = 5;

  // valid ranges
  localparam logic [7:0] ROW_MAX = 8'h83;
  localparam logic [7:0] MUX_MIN = 8'h0F;
  localparam logic [7:0] MUX_MAX = 8'h83;
  localparam logic [3:0] PHASE1_MIN = 4'h1;
  localparam logic [3:0] PHASE2_MIN = 4'h2;

  // reset values
  localparam logic [1:0] RST_SPEED = 2'h2;
  localparam logic [7:0] RST_REMAP = 8'h40;
  localparam logic [7:0] RST_START = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_MUX = 8'h83;
  localparam logic [7:0] RST_DIM = 8'h00;
  localparam logic [4:0] RST_DIM_PRE = 5'h00;
  localparam logic [4:0] RST_PHASE1_CYC = 5'h09;
  localparam logic [3:0] RST_PHASE2_CYC = 4'h7;
  localparam logic [3:0] RST_DIV = 4'h0;

  // remap field positions
  localparam int REMAP_VERT_BIT = 0;
  localparam int REMAP_SEGREV_BIT = 1;
  localparam int REMAP_ORDER_BIT = 2;
  localparam int REMAP_SWAP_BIT = 3;
  localparam int REMAP_SCANREV_BIT = 4;
  localparam int REMAP_SPLIT_BIT = 5;
  localparam int REMAP_DEPTH_LSB = 6;
  localparam int REMAP_DEPTH_MSB = 7;
  localparam logic [1:0] DEPTH_256K = 2'h2;

  // register byte offsets and fields
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_REMAP_STATUS = 8'h08;
  localparam logic [7:0] REG_LINES = 8'h0C;
  localparam logic [7:0] REG_DIM = 8'h10;
  localparam logic [7:0] REG_PHASE = 8'h14;
  localparam int CMD_DC_BIT = 8;
  localparam int CFG_WIDE_BIT = 0;
  localparam int CFG_DIV_LSB = 4;
  localparam int CFG_DIV_MSB = 7;

  // second pre-charge speed codes
  typedef enum logic [1:0] {
    SPEED_SLOWEST = 2'h0,
    SPEED_SLOW = 2'h1,
    SPEED_NORMAL = 2'h2,
    SPEED_FAST = 2'h3
  } odc_speed_t;

  // power states
  typedef enum logic [1:0] {
    PWR_SLEEP = 2'h0,
    PWR_NORMAL = 2'h1,
    PWR_DIM = 2'h3
  } odc_power_t;

  // display modes, equal to the low opcode bits
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_ALL_ON = 2'h1,
    MODE_ALL_OFF = 2'h2,
    MODE_INVERSE = 2'h3
  } odc_dmode_t;

  // interpreter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COLLECT = 2'b01,
    ST_APPLY = 2'b11
  } odc_state_t;
endpackage
`default_nettype wire

//--- rtl/odc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module odc_clk_div #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // divider setting, period is divider plus one
  input wire logic [WIDTH-1:0] divider,
  // one-cycle enable per divided period
  output logic tick
);
  logic [WIDTH-1:0] count;
  wire wrap = (count >= divider);

  // period counter, tick on wrap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + WIDTH'(1);
      tick <= wrap;
    end
  end
endmodule
`default_nettype wire

//--- rtl/odc_phase_seq.sv
`timescale 1ns/1ps
`default_nettype none
module odc_phase_seq (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // divided display clock enable and run gate
  input wire logic tick,
  input wire logic run,
  // phase lengths in divided clocks
  input wire logic [4:0] phase1Len,
  input wire logic [3:0] phase2Len,
  // phase indications
  output logic phase1Active,
  output logic phase2Active
);
  logic [4:0] count;
  // at-or-past compare, so a length cut mid-phase ends it on the next tick
  wire last1 = (count >= (phase1Len - 5'h01));
  wire last2 = (count >= ({1'b0, phase2Len} - 5'h01));

  // alternate phase 1 and phase 2, counting divided clocks
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      phase1Active <= 1'b0;
      phase2Active <= 1'b0;
      count <= 5'h00;
    end else if (!phase1Active && !phase2Active) begin
      phase1Active <= 1'b1;
      count <= 5'h00;
    end else if (tick) begin
      if (phase1Active ? last1 : last2) begin
        phase1Active <= phase2Active;
        phase2Active <= phase1Active;
        count <= 5'h00;
      end else begin
        count <= count + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/odc_config_props.sv
`timescale 1ns/1ps
`default_nettype none
module odc_config_props #(
  parameter int DIV_WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus handshake
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // settings
  input wire logic [7:0] startLine,
  input wire logic [7:0] displayOffset,
  input wire logic [7:0] muxRatio,
  input wire logic [1:0] displayMode,
  input wire logic [1:0] powerState,
  input wire logic [4:0] phase1Cycles,
  input wire logic [3:0] phase2Cycles,
  input wire logic phase1Active,
  input wire logic phase2Active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // request seen, command byte taken
  wire logic req = avs_read || avs_write;
  wire logic cmdTake = avs_write && !avs_waitrequest && avs_address == 8'h00;
  // waiting request, then a one-cycle answer
  sequence s_pending;
    req && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // a setting moves only two or three edges after a command write
  property p_by_cmd(logic [1:0] sig);
    $changed(sig) |-> $past(cmdTake, 2) || $past(cmdTake, 3);
  endproperty
  a_answer_one_cycle: assert property (s_pending |=> s_answer)
    else $error("answer not one cycle after request");
  a_idle_no_answer: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  a_start_range: assert property (startLine <= 8'h83)
    else $error("start line out of range");
  a_offset_range: assert property (displayOffset <= 8'h83)
    else $error("offset out of range");
  a_mux_range: assert property (muxRatio >= 8'h0F && muxRatio <= 8'h83)
    else $error("mux ratio out of range");
  a_phase1_legal: assert property (phase1Cycles[0] && phase1Cycles >= 5'h03)
    else $error("phase 1 length illegal");
  a_phase2_legal: assert property (phase2Cycles >= 4'h2)
    else $error("phase 2 length illegal");
  a_phases_apart: assert property (!(phase1Active && phase2Active))
    else $error("both phases active");
  a_sleep_dark: assert property (powerState == 2'h0 && $past(powerState) == 2'h0
    |-> !phase1Active && !phase2Active)
    else $error("phase active in sleep");
  a_mode_by_cmd: assert property (p_by_cmd(displayMode))
    else $error("mode changed without command");
  a_power_by_cmd: assert property (p_by_cmd(powerState))
    else $error("power changed without command");
endmodule
bind odc_config_cmds odc_config_props #(.DIV_WIDTH(DIV_WIDTH)) u_odc_config_props (
  .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_waitrequest, .startLine,
  .displayOffset, .muxRatio, .displayMode, .powerState, .phase1Cycles, .phase2Cycles,
  .phase1Active, .phase2Active);
`default_nettype wire

//--- verification/odc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module odc_host_model (
  // clock
  input wire logic ref_clk,
  // avalon-mm master
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  int tmo = 0;
  // idle bus at time zero
  initial begin
    avs_address = 8'hFF;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= 4'hF;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      tmo++;
    end
    // released lines carry no stale value
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
    avs_byteenable <= 4'h0;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- verification/odc_config_cmds_test.sv
`timescale 1ns/1ps
`default_nettype none
module odc_config_cmds_test;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, addrVertical, segRemap;
  logic subpixelReverse, comSwap, comReverse, comSplit;
  logic displayClockTick, phase1Active, phase2Active;
  logic [7:0] avs_address, startLine, displayOffset, muxRatio;
  logic [7:0] dimContrastA, dimContrastB, dimContrastC;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, phase2Cycles;
  logic [1:0] prechargeSpeed, colourDepth, displayMode, powerState;
  logic [4:0] dimPrecharge, phase1Cycles;
  logic [5:0] remapBits;
  int err_count = 0;
  int num_checks = 0;
  assign remapBits = {comSplit, comReverse, comSwap, subpixelReverse, segRemap, addrVertical};
  // device and host
  odc_config_cmds #(.DIV_WIDTH(4)) u_odc_config_cmds (
    .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .prechargeSpeed, .addrVertical, .segRemap,
    .subpixelReverse, .comSwap, .comReverse, .comSplit, .colourDepth, .startLine,
    .displayOffset, .muxRatio, .displayMode, .powerState, .dimContrastA, .dimContrastB,
    .dimContrastC, .dimPrecharge, .phase1Cycles, .phase2Cycles, .displayClockTick,
    .phase1Active, .phase2Active);
  odc_host_model u_odc_host_model (
    .ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // bus transfer, a hang ends the run
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    u_odc_host_model.xfer(wr, a, d, q);
    if (u_odc_host_model.tmo != 0) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic cmd(input logic [7:0] b, input logic isPar);
    bus(1'b1, 8'h00, {23'h0, isPar, b});
  endtask
  task automatic settle;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic set1(input logic [7:0] op, input logic [7:0] p);
    cmd(op, 1'b0);
    cmd(p, 1'b1);
    settle();
  endtask
  task automatic t_reset;
    check(prechargeSpeed, 32'h2);
    check(remapBits, 32'h0);
    check(colourDepth, 32'h1);
    check({startLine, displayOffset, muxRatio}, 32'h83);
    check({displayMode, powerState}, 32'h0);
    check({phase2Cycles, 3'h0, phase1Cycles}, 32'h709);
  endtask
  task automatic t_remap;
    for (int k = 0; k < 4; k++) begin
      set1(8'h8A, 8'(k));
      check(prechargeSpeed, 32'(k));
    end
    for (int i = 0; i < 6; i++) begin
      set1(8'hA0, 8'h40 | 8'(1 << i));
      check(remapBits, 32'(1 << i));
    end
    for (int d = 0; d < 4; d++) begin
      set1(8'hA0, 8'(d << 6));
      check(colourDepth, 32'(d));
    end
    bus(1'b1, 8'h04, 32'h1);
    settle();
    check(colourDepth, 32'h2);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    check(q, 32'h000033C0);
    bus(1'b0, 8'h3C, 32'h0);
    check(q, 32'h0);
  endtask
  task automatic t_rows;
    set1(8'hA1, 8'h83);
    check(startLine, 32'h83);
    set1(8'hA1, 8'h84);
    check(startLine, 32'h83);
    set1(8'hA1, 8'h00); // zeroed for later use
    check(startLine, 32'h0);
    set1(8'hA2, 8'h83);
    set1(8'hA2, 8'hC8);
    check(displayOffset, 32'h83);
    set1(8'hA8, 8'h0F);
    check(muxRatio, 32'h0F);
    set1(8'hA8, 8'h0E);
    check(muxRatio, 32'h0F);
    for (int m = 0; m < 4; m++) begin
      cmd(8'hA4 + 8'(m), 1'b0);
      settle();
      check(displayMode, 32'(m));
    end
  endtask
  task automatic t_dim;
    cmd(8'hAB, 1'b0);
    cmd(8'h00, 1'b1); // reserved byte zero
    cmd(8'h11, 1'b1);
    cmd(8'h22, 1'b1);
    cmd(8'h33, 1'b1);
    settle();
    check(dimContrastA, 32'h0);
    cmd(8'h1F, 1'b1);
    settle();
    check({dimContrastA, dimContrastB, dimContrastC, 3'h0, dimPrecharge}, 32'h1122331F);
    // abort mid-sequence, then a stray parameter
    cmd(8'hAB, 1'b0);
    cmd(8'h00, 1'b1);
    cmd(8'h55, 1'b1);
    cmd(8'hAF, 1'b0);
    cmd(8'h66, 1'b1);
    settle();
    check({powerState, dimContrastA}, 32'h111);
  endtask
  task automatic t_phase;
    int n;
    bus(1'b1, 8'h04, 32'h10);
    set1(8'hB1, 8'h32);
    check({phase2Cycles, 3'h0, phase1Cycles}, 32'h305);
    // divider one: tick every second cycle
    n = 0;
    while (displayClockTick !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    check(displayClockTick, 32'h0);
    @(posedge ref_clk);
    check(displayClockTick, 32'h1);
    n = 0;
    while (phase1Active === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    while (phase1Active !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (phase1Active === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check(n, 32'd10);
    n = 0;
    while (phase2Active === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check(n, 32'd6);
    set1(8'hB1, 8'h10);
    check({phase2Cycles, 3'h0, phase1Cycles}, 32'h305);
    set1(8'hB1, 8'h05);
    check({phase2Cycles, 3'h0, phase1Cycles}, 32'h30B);
    cmd(8'hAC, 1'b0);
    settle();
    check(powerState, 32'h3);
    cmd(8'hAE, 1'b0);
    settle();
    check({powerState, phase1Active, phase2Active}, 32'h0);
  endtask
  // reset, then the scenarios
  initial begin
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_remap();
    t_rows();
    t_dim();
    t_phase();
    end_of_test();
  end
endmodule
`default_nettype wire
